// *** rtl/ssm_consts.svh ***
// ssm_consts.svh: offsets-free constants for the slave state machine block
// assumes inclusion by rtl and bench files of the ssm block only
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH
`define SSM_CLK_PERIOD_NS     32'd100
`define SSM_DC_STEP_NS        64'd100
`define SSM_WD_BASE_TICK_NS   32'd40
`define SSM_WD_MULT_RESET     16'h09C2
`define SSM_WD_COUNT_RESET    16'h03E8
`define SSM_AL_CODE_NONE      8'h00
`define SSM_AL_CODE_BAD_TRANS 8'h11
`define SSM_AL_CODE_BAD_MBX   8'h16
`define SSM_AL_CODE_BAD_PD    8'h1D
`define SSM_AL_CODE_BAD_DC    8'h30
`endif

// *** rtl/ssm_pkg.sv ***
// ssm_pkg.sv: types shared by the slave state machine block
// assumes the constants header is included by the modules that need it
package ssm_pkg;
  typedef enum logic [2:0] {
    SSM_INIT,
    SSM_PREOP,
    SSM_SAFEOP,
    SSM_OP,
    SSM_BOOT
  } ssm_state_e;

  typedef struct packed {
    logic       valid;
    ssm_state_e target;
  } ssm_req_s;

  typedef struct packed {
    logic mbx_ok;
    logic pd_ok;
    logic dc_used;
    logic dc_ok;
  } ssm_cfg_s;

  typedef struct packed {
    logic        set;
    logic [63:0] value;
  } ssm_time_set_s;

  typedef logic [15:0] ssm_word_t;
endpackage : ssm_pkg

// *** rtl/ssm_watchdog.sv ***
// ssm_watchdog.sv: process-data watchdog with 40 ns base ticks
// assumes same-clock restart pulses and static multiplier/count settings
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"
module ssm_watchdog
  import ssm_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      srst,
  // settings
  input  wire ssm_word_t wd_mult,
  input  wire ssm_word_t wd_count,
  // events
  input  wire logic      restart,
  output logic           expired_q
);
  // one clock covers 2.5 base ticks, so elapsed time is summed in ns
  // and the residue past each watchdog tick is carried into the next
  logic [31:0] acc_ns_q;
  logic [31:0] acc_next;
  logic [31:0] tick_len_ns;
  logic [15:0] tick_q;
  logic        wd_tick;

  assign tick_len_ns = ({16'h0000, wd_mult} + 32'h00000002) * `SSM_WD_BASE_TICK_NS;
  assign acc_next    = acc_ns_q + `SSM_CLK_PERIOD_NS;
  assign wd_tick     = acc_next >= tick_len_ns;

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      acc_ns_q <= 32'h00000000;
    end else if (wd_tick) begin
      // limitation: a zero multiplier gives ticks shorter than a clock and runs slow
      acc_ns_q <= acc_next - tick_len_ns;
    end else begin
      acc_ns_q <= acc_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      tick_q    <= 16'h0000;
      expired_q <= 1'b0;
    end else if (wd_count == 16'h0000) begin
      tick_q    <= 16'h0000;
      expired_q <= 1'b0;
    end else if (wd_tick && !expired_q) begin
      tick_q <= tick_q + 16'h0001;
      if (tick_q + 16'h0001 >= wd_count) begin
        expired_q <= 1'b1;
      end
    end
  end
endmodule : ssm_watchdog
`default_nettype wire

// *** rtl/ssm_slave.sv ***
// ssm_slave.sv: slave communication state machine, traffic gating,
// safe-output control and nanosecond local clock, 64-bit or 32-bit with REDUCED_DC
// assumes all inputs come from logic on clk; the master side requests states
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"
module ssm_slave
  import ssm_pkg::*;
#(
  parameter int OUT_W      = 16,
  parameter int IN_W       = 16,
  parameter bit REDUCED_DC = 1'b0
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // state requests from the master side
  input  wire ssm_req_s        req,
  input  wire ssm_cfg_s        cfg,
  input  wire logic            err_ack,
  output ssm_state_e           state_q,
  output logic                 ack_q,
  output logic                 err_q,
  output logic [7:0]           err_code_q,
  // mailbox gating
  input  wire logic            mbx_req,
  input  wire logic            mbx_is_file,
  output logic                 mbx_accept,
  output logic                 mbx_reject,
  // process data
  input  wire logic            pd_req,
  output logic                 pd_accept,
  output logic                 pd_reject,
  input  wire logic [OUT_W-1:0] pd_out_data,
  input  wire logic            pd_out_valid,
  // application inputs and outputs
  input  wire logic [IN_W-1:0] app_in,
  input  wire logic [OUT_W-1:0] safe_value,
  output logic [IN_W-1:0]      mem_in_q,
  output logic                 mem_in_we_q,
  output logic [OUT_W-1:0]     app_out_q,
  output logic                 outputs_safe,
  // watchdog settings
  input  wire ssm_word_t       wd_mult,
  input  wire ssm_word_t       wd_count,
  output logic                 wd_expired,
  // distributed clock
  input  wire ssm_time_set_s   time_set,
  input  wire logic signed [31:0] time_adj,
  input  wire logic            time_adj_stb,
  output logic [63:0]          local_time_q
);
  // a Safe_operational_state request from SSM_PREOP first spends one cycle copying inputs, then acks
  logic        copy_pend_q;
  logic        pd_en;
  logic        wd_restart;
  logic        refuse;
  logic [7:0]  refuse_code;
  logic        copy_start;

  assign pd_en = (state_q == SSM_SAFEOP) || (state_q == SSM_OP);

  // mailbox and process data gating per state
  always_comb begin
    mbx_accept = 1'b0;
    unique case (state_q)
      SSM_INIT:   mbx_accept = 1'b0;
      SSM_PREOP:  mbx_accept = mbx_req;
      SSM_SAFEOP: mbx_accept = mbx_req;
      SSM_OP:     mbx_accept = mbx_req;
      SSM_BOOT:   mbx_accept = mbx_req && mbx_is_file;
    endcase
  end
  assign mbx_reject = mbx_req && !mbx_accept;
  assign pd_accept  = pd_req && pd_en;
  assign pd_reject  = pd_req && !pd_en;
  assign wd_restart = pd_accept;

  // transition check
  always_comb begin
    refuse      = 1'b0;
    refuse_code = `SSM_AL_CODE_NONE;
    unique case (req.target)
      SSM_INIT: begin
        refuse = 1'b0;
      end
      SSM_PREOP: begin
        if (state_q == SSM_BOOT) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_TRANS;
        end else if (state_q == SSM_INIT && !cfg.mbx_ok) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_MBX;
        end
      end
      SSM_SAFEOP: begin
        if (state_q == SSM_INIT || state_q == SSM_BOOT) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_TRANS;
        end else if (state_q == SSM_PREOP && !cfg.pd_ok) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_PD;
        end else if (state_q == SSM_PREOP && cfg.dc_used && !cfg.dc_ok) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_DC;
        end
      end
      SSM_OP: begin
        // Op only from Safe_operational_state or Op itself; it is where start-up ends
        if (state_q != SSM_SAFEOP && state_q != SSM_OP) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_TRANS;
        end
      end
      SSM_BOOT: begin
        if (state_q != SSM_INIT && state_q != SSM_BOOT) begin
          refuse      = 1'b1;
          refuse_code = `SSM_AL_CODE_BAD_TRANS;
        end
      end
      default: begin
        refuse      = 1'b1;
        refuse_code = `SSM_AL_CODE_BAD_TRANS;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q     <= SSM_INIT;
      copy_pend_q <= 1'b0;
      ack_q       <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      if (copy_pend_q) begin
        copy_pend_q <= 1'b0;
        state_q     <= SSM_SAFEOP;
        ack_q       <= 1'b1;
      end else if (req.valid && !refuse) begin
        if (req.target == SSM_SAFEOP && state_q == SSM_PREOP) begin
          copy_pend_q <= 1'b1;
        end else begin
          state_q <= req.target;
          ack_q   <= 1'b1;
        end
      end
    end
  end

  // error flag: a new refusal wins over the acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      err_q      <= 1'b0;
      err_code_q <= `SSM_AL_CODE_NONE;
    end else if (req.valid && refuse && !copy_pend_q) begin
      err_q      <= 1'b1;
      err_code_q <= refuse_code;
    end else if (err_ack) begin
      err_q      <= 1'b0;
      err_code_q <= `SSM_AL_CODE_NONE;
    end
  end

  // the copy lands on the accepting edge, a full cycle ahead of the Safe_operational_state ack
  assign copy_start = req.valid && !refuse && !copy_pend_q && req.target == SSM_SAFEOP
    && state_q == SSM_PREOP;

  // inputs into the dual-port memory: at the Safe_operational_state copy and every cycle in Safe_operational_state or Op
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_in_q    <= '0;
      mem_in_we_q <= 1'b0;
    end else begin
      mem_in_we_q <= copy_start || pd_en;
      if (copy_start || pd_en) begin
        mem_in_q <= app_in;
      end
    end
  end

  ssm_watchdog u_wd (
    .clk       (clk),
    .srst      (srst),
    .wd_mult   (wd_mult),
    .wd_count  (wd_count),
    .restart   (wd_restart),
    .expired_q (wd_expired)
  );

  // outputs follow master data only in Op with a healthy or disabled watchdog;
  // Safe_operational_state holds them safe, accepting the off state over any stale data
  assign outputs_safe = !(state_q == SSM_OP) || wd_expired;

  always_ff @(posedge clk) begin
    if (srst || outputs_safe) begin
      app_out_q <= safe_value;
    end else if (pd_out_valid && pd_accept) begin
      app_out_q <= pd_out_data;
    end
  end

  // local time in ns, stepped by the clock period; master may load or nudge it
  always_ff @(posedge clk) begin
    if (srst) begin
      local_time_q <= 64'h0000000000000000;
    end else if (time_set.set) begin
      local_time_q <= REDUCED_DC ? {32'h00000000, time_set.value[31:0]} : time_set.value;
    end else if (time_adj_stb) begin
      local_time_q <= REDUCED_DC
        ? {32'h00000000, 32'(local_time_q[31:0] + `SSM_DC_STEP_NS + 64'(time_adj))}
        : local_time_q + `SSM_DC_STEP_NS + 64'(time_adj);
    end else if (REDUCED_DC) begin
      local_time_q <= {32'h00000000, 32'(local_time_q[31:0] + `SSM_DC_STEP_NS)};
    end else begin
      local_time_q <= local_time_q + `SSM_DC_STEP_NS;
    end
  end
endmodule : ssm_slave
`default_nettype wire

// *** bench/ssm_slave_assertions.sv ***
// ssm_slave_assertions.sv: port-level checker for the slave state machine
// assumes it is bound to ssm_slave and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module ssm_slave_assertions
  import ssm_pkg::*;
(
  // clock, reset and requests
  input wire logic          clk,
  input wire logic          srst,
  input wire ssm_req_s      req,
  input wire ssm_cfg_s      cfg,
  // observed behaviour
  input wire ssm_state_e    state_q,
  input wire logic          ack_q,
  input wire logic          err_q,
  input wire logic          mbx_req,
  input wire logic          mbx_is_file,
  input wire logic          mbx_accept,
  input wire logic          pd_accept,
  input wire logic          mem_in_we_q,
  input wire logic          outputs_safe,
  input wire logic          wd_expired,
  input wire ssm_time_set_s time_set,
  input wire logic          time_adj_stb,
  input wire logic [63:0]   local_time_q,
  input wire logic [15:0]   app_out_q,
  input wire logic [15:0]   safe_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  init_quiet_a: assert property (state_q == SSM_INIT |-> !mbx_accept && !pd_accept)
    else $error("traffic accepted in init");
  preop_mbx_a: assert property (state_q == SSM_PREOP |-> !pd_accept && mbx_accept == mbx_req)
    else $error("wrong gating in preop");
  boot_file_a: assert property (state_q == SSM_BOOT |-> !pd_accept && mbx_accept == (mbx_req && mbx_is_file))
    else $error("wrong gating in boot");
  boot_entry_a: assert property (req.valid && req.target == SSM_BOOT && !(state_q inside {SSM_INIT, SSM_BOOT})
    |=> err_q && state_q == $past(state_q))
    else $error("boot entered from wrong state");
  copy_then_ack_a: assert property (state_q == SSM_PREOP && req.valid && req.target == SSM_SAFEOP && cfg.pd_ok
    && (!cfg.dc_used || cfg.dc_ok) |=> mem_in_we_q && !ack_q ##1 ack_q && state_q == SSM_SAFEOP)
    else $error("input copy not ahead of ack");
  outputs_safe_a: assert property (state_q != SSM_OP || wd_expired |-> outputs_safe)
    else $error("outputs live outside op");
  safe_hold_a: assert property (state_q != SSM_OP || wd_expired |=> app_out_q == $past(safe_value))
    else $error("outputs not held safe");
  time_step_a: assert property (!time_set.set && !time_adj_stb |=> local_time_q == $past(local_time_q) + 64'h64)
    else $error("local time step wrong");
  wd_keeps_state_a: assert property ($rose(wd_expired) && !ack_q |-> $stable(state_q))
    else $error("watchdog changed state");
  cover property (ack_q && state_q == SSM_OP);
  cover property ($rose(wd_expired));
  cover property (state_q == SSM_BOOT && mbx_accept);
endmodule : ssm_slave_assertions
`default_nettype wire

// *** bench/ssm_master_model.sv ***
// ssm_master_model.sv: bus master stand-in that requests state changes
// assumes it shares clk with the slave and is driven by bench tasks
`timescale 1ns/1ps
`default_nettype none
module ssm_master_model
  import ssm_pkg::*;
(
  // clock
  input  wire logic     clk,
  // request side
  output var ssm_req_s  req,
  output var ssm_cfg_s  cfg
);
  initial begin
    req = '0;
    cfg = '0;
  end
  // cfg reports the channel setup written before asking
  task automatic ask(input ssm_state_e t, input ssm_cfg_s c);
    @(posedge clk);
    req <= '{valid: 1'b1, target: t};
    cfg <= c;
    @(posedge clk);
    req <= '0;
  endtask : ask
endmodule : ssm_master_model
`default_nettype wire

// *** bench/ssm_slave_tb_top.sv ***
// ssm_slave_tb_top.sv: scenario bench for the slave state machine
// assumes the master model issues requests and the checker is bound below
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"
module ssm_slave_tb_top;
  import ssm_pkg::*;
  logic clk, srst, err_ack, mbx_req, mbx_is_file, pd_req, pd_out_valid, time_adj_stb;
  logic ack_q, err_q, mbx_accept, mbx_reject, pd_accept, pd_reject, mem_in_we_q, outputs_safe, wd_expired;
  logic [15:0]        pd_out_data, app_in, safe_value, mem_in_q, app_out_q;
  logic [7:0]         err_code_q;
  logic [63:0]        local_time_q;
  logic signed [31:0] time_adj;
  ssm_word_t          wd_mult, wd_count;
  ssm_req_s           req;
  ssm_cfg_s           cfg;
  ssm_state_e         state_q;
  ssm_time_set_s      time_set;
  int                 error_cnt, num_checks, cyc;
  localparam ssm_cfg_s OK = 4'hF;
  ssm_master_model mdl (.clk, .req, .cfg);
  ssm_slave uut (.clk, .srst, .req, .cfg, .err_ack, .state_q, .ack_q, .err_q, .err_code_q, .mbx_req,
    .mbx_is_file, .mbx_accept, .mbx_reject, .pd_req, .pd_accept, .pd_reject, .pd_out_data, .pd_out_valid,
    .app_in, .safe_value, .mem_in_q, .mem_in_we_q, .app_out_q, .outputs_safe, .wd_mult, .wd_count,
    .wd_expired, .time_set, .time_adj, .time_adj_stb, .local_time_q);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic go(input ssm_state_e t);
    mdl.ask(t, OK);
    #1;
    chk("ack", ack_q, 1'b1);
    chk("state", state_q, t);
  endtask : go
  task automatic refuse(input ssm_state_e t, input ssm_cfg_s c, input logic [7:0] code);
    ssm_state_e s;
    s = state_q;
    mdl.ask(t, c);
    #1;
    chk("err", err_q, 1'b1);
    chk("code", err_code_q, code);
    chk("kept", state_q, s);
    @(posedge clk);
    err_ack <= 1'b1;
    @(posedge clk);
    err_ack <= 1'b0;
  endtask : refuse
  task automatic t_startup;
    @(posedge clk);
    #1;
    chk("reset state", state_q, SSM_INIT);
    chk("init mbx", mbx_accept, 1'b0);
    refuse(SSM_PREOP, 4'h0, `SSM_AL_CODE_BAD_MBX);
    go(SSM_PREOP);
    chk("preop pd", pd_accept, 1'b0);
    refuse(SSM_SAFEOP, 4'hB, `SSM_AL_CODE_BAD_PD);
    refuse(SSM_SAFEOP, 4'hE, `SSM_AL_CODE_BAD_DC);
    refuse(SSM_BOOT, OK, `SSM_AL_CODE_BAD_TRANS);
    app_in <= 16'h3C5A;
    mdl.ask(SSM_SAFEOP, OK);
    #1;
    chk("copy", mem_in_q, 16'h3C5A);
    chk("early ack", ack_q, 1'b0);
    chk("copy we", mem_in_we_q, 1'b1);
    @(posedge clk);
    pd_out_data <= 16'h9E21;
    pd_out_valid <= 1'b1;
    app_in <= 16'h0F0F;
    #1;
    chk("safeop", state_q, SSM_SAFEOP);
    chk("safeop pd", pd_accept, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk("refresh", mem_in_q, 16'h0F0F);
    chk("held", app_out_q, safe_value);
    go(SSM_OP);
    @(posedge clk);
    #1;
    chk("applied", app_out_q, 16'h9E21);
    $display("startup test done");
  endtask : t_startup
  task automatic t_watchdog;
    @(posedge clk);
    pd_req <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    chk("wd off", wd_expired, 1'b0);
    chk("live", app_out_q, 16'h9E21);
    @(posedge clk);
    pd_req <= 1'b1;
    wd_mult <= 16'h0003;
    wd_count <= 16'h0004;
    @(posedge clk);
    pd_req <= 1'b0;
    // (3 + 2) x 40 ns x 4 ticks = 800 ns: trips on the 8th edge after the restart
    repeat (7) @(posedge clk);
    #1;
    chk("wd early", wd_expired, 1'b0);
    @(posedge clk);
    #1;
    chk("wd fired", wd_expired, 1'b1);
    @(posedge clk);
    #1;
    chk("wd safe", app_out_q, safe_value);
    chk("wd state", state_q, SSM_OP);
    $display("watchdog test done");
  endtask : t_watchdog
  task automatic t_boot;
    @(posedge clk);
    pd_req <= 1'b1;
    wd_count <= 16'h0000;
    go(SSM_INIT);
    chk("init safe", outputs_safe, 1'b1);
    go(SSM_BOOT);
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      mbx_is_file <= f[0];
      #1;
      chk("boot mbx", mbx_accept, f[0]);
      chk("boot mbx rej", mbx_reject, !f[0]);
    end
    chk("boot pd", pd_accept, 1'b0);
    chk("boot pd rej", pd_reject, 1'b1);
    refuse(SSM_PREOP, OK, `SSM_AL_CODE_BAD_TRANS);
    $display("boot test done");
  endtask : t_boot
  task automatic t_time;
    @(posedge clk);
    time_set <= '{set: 1'b1, value: 64'h1_0000_0000};
    @(posedge clk);
    time_set <= '0;
    time_adj <= 32'shFFFF_FFE2;
    time_adj_stb <= 1'b1;
    #1;
    chk("load", local_time_q, 64'h1_0000_0000);
    @(posedge clk);
    time_adj_stb <= 1'b0;
    #1;
    chk("adjust", local_time_q, 64'h1_0000_0046);
    @(posedge clk);
    #1;
    chk("run", local_time_q, 64'h1_0000_00AA);
    $display("time test done");
  endtask : t_time
  initial begin
    {srst, err_ack, mbx_req, mbx_is_file, pd_req, pd_out_valid, time_adj_stb} = 7'h54;
    {pd_out_data, app_in, time_adj} = '0;
    safe_value = 16'h00C3;
    {wd_mult, wd_count} = '0;
    time_set = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_startup();
    t_watchdog();
    t_boot();
    t_time();
    conclude();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      conclude();
    end
  end
endmodule : ssm_slave_tb_top
bind ssm_slave ssm_slave_assertions chk_i (.clk, .srst, .req, .cfg, .state_q, .ack_q, .err_q, .mbx_req,
  .mbx_is_file, .mbx_accept, .pd_accept, .mem_in_we_q, .outputs_safe, .wd_expired, .time_set,
  .time_adj_stb, .local_time_q, .app_out_q, .safe_value);
`default_nettype wire
